// File: hw/scp_ctrl.sv
// scp_ctrl: software-mode serial control port, the first three
// transmitter configuration registers and the line driver source mux.
// assumes: port_clock is the host's port clock, idle outside accesses;
// port_select_n is the host's active-low select; clk_sys runs free.
`timescale 1ns/1ps
`include "scp_map.svh"

// Functional notes
// - bypass bit picks encoder or external encoded input
// - hardware mode always uses internal encoder
// - reset or power-down grounds line outputs
// - output-disable bit grounds line outputs in software mode
// - serial out released unless reading with select low
// - input sampled rising, output changed falling port edge
// - every byte moves most significant bit first
// - header byte: rw, step, 6-bit address; byte two ignored
// - address advances by one, or two with step
// - write stores data bytes at advancing addresses
// - read shifts addressed byte right after header
// - block start direction bit sets pin direction
// - validity bit marks valid pcm or not
// - mute bit sends zero samples both subframes
// - mono bit picks stereo or mono transmission
// - mono select picks left or right source
// - shared status bit duplicates selected status
// - clock ratio code gives 128/256/384/512 fs
// - soft reset bit holds device in reset
// - role bit and bit clock rate in master
// - word length code and justification select
// - delay bit starts data first or second period
// - edge bit picks rising or falling sampling
// - sync polarity bit picks left channel phase
module scp_ctrl
    import scp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic port_clock,
    input wire logic port_select_n,
    input wire logic port_serial_in,
    output logic port_serial_out,
    output logic port_serial_out_oe,
    input wire logic hardware_mode,
    input wire logic encoder_data,
    input wire logic external_encoded_input,
    output logic line_out_pos,
    output logic line_out_neg,
    output logic block_start_direction,
    output logic validity_flag,
    output logic mute,
    output logic mono,
    output logic mono_channel_select,
    output logic shared_status_select,
    output logic mono_audio_right,
    output logic status_a_right,
    output logic status_b_right,
    output logic power_down,
    output logic soft_reset,
    output logic [1:0] mclk_ratio,
    output logic audio_port_master,
    output logic bit_clock_rate,
    output logic [1:0] word_length,
    output logic justification,
    output logic data_delay,
    output logic bit_clock_edge,
    output logic frame_sync_polarity
);

    // ------------------------------------------------------------------
    // register read decode, used for the header load and each next byte
    // ------------------------------------------------------------------
    function automatic scp_byte_t scp_read_mux(input logic [5:0] addr,
                                               input scp_byte_t tx_ctrl,
                                               input scp_byte_t pwr_clk,
                                               input scp_byte_t aport);
        scp_byte_t data;
        data = 8'h00;
        if (addr == `SCP_ADDR_TX_CTRL) begin
            data = tx_ctrl;
        end else if (addr == `SCP_ADDR_PWR_CLK) begin
            data = pwr_clk & `SCP_PWR_CLK_MASK;
        end else if (addr == `SCP_ADDR_AUDIO_PORT) begin
            data = aport;
        end

        return data;
    endfunction : scp_read_mux

    // ------------------------------------------------------------------
    // port clock domain: protocol state
    // ------------------------------------------------------------------
    scp_phase_t phase_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_in_reg;

    logic rw_reg;
    logic step_reg;
    logic [5:0] addr_reg;
    scp_byte_t rd_byte_reg;

    // register images
    scp_byte_t tx_ctrl_reg;
    scp_byte_t pwr_clk_reg;
    scp_byte_t aport_reg;

    // helpers
    scp_byte_t in_byte;
    logic byte_done;
    logic wr_strobe;
    logic [5:0] addr_next;

    // assembled byte: seven earlier bits plus the one now on the pin
    assign in_byte = {shift_in_reg, port_serial_in};
    assign byte_done = (bit_cnt_reg == `SCP_LAST_BIT);
    assign wr_strobe = byte_done && (phase_reg == SCP_PH_DATA) && !rw_reg;

    // step selects an increment of one or two
    assign addr_next = addr_reg + (step_reg ? 6'h02 : 6'h01);

    // protocol runs on rising port edges; select high clears it at once,
    // so a partial byte is dropped and the next access starts at a header
    always_ff @(posedge port_clock or posedge port_select_n or posedge rst) begin
        if (rst || port_select_n) begin
            phase_reg <= SCP_PH_HDR0;
            bit_cnt_reg <= 3'h0;
            shift_in_reg <= 7'h00;
            rw_reg <= 1'b0;
            step_reg <= 1'b0;
            addr_reg <= 6'h00;
            rd_byte_reg <= 8'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_in_reg <= in_byte[6:0];

            if (byte_done) begin
                case (phase_reg)
                    SCP_PH_HDR0: begin
                        // first header byte carries direction, step, address
                        rw_reg <= in_byte[`SCP_HDR_RW];
                        step_reg <= in_byte[`SCP_HDR_STEP];
                        addr_reg <= in_byte[5:0];
                        phase_reg <= SCP_PH_HDR1;
                    end

                    SCP_PH_HDR1: begin
                        // second header byte is don't-care; preload read data
                        phase_reg <= SCP_PH_DATA;
                        rd_byte_reg <= scp_read_mux(addr_reg, tx_ctrl_reg,
                                                    pwr_clk_reg, aport_reg);
                    end

                    SCP_PH_DATA: begin
                        addr_reg <= addr_next;
                        rd_byte_reg <= scp_read_mux(addr_next, tx_ctrl_reg,
                                                    pwr_clk_reg, aport_reg);
                    end

                    // one-hot codes never reach here
                    default: begin
                        phase_reg <= SCP_PH_HDR0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration registers, written from the port clock domain
    // ------------------------------------------------------------------
    // only the system reset clears them; select edges must not disturb them
    always_ff @(posedge port_clock or posedge rst) begin
        if (rst) begin
            tx_ctrl_reg <= `SCP_RST_TX_CTRL;
            pwr_clk_reg <= `SCP_RST_PWR_CLK;
            aport_reg <= `SCP_RST_AUDIO_PORT;
        end else if (wr_strobe) begin
            if (addr_reg == `SCP_ADDR_TX_CTRL) begin
                tx_ctrl_reg <= in_byte;
            end else if (addr_reg == `SCP_ADDR_PWR_CLK) begin
                pwr_clk_reg <= in_byte & `SCP_PWR_CLK_MASK;
            end else if (addr_reg == `SCP_ADDR_AUDIO_PORT) begin
                aport_reg <= in_byte;
            end
        end
    end

    // ------------------------------------------------------------------
    // serial output, changed on falling port edges
    // ------------------------------------------------------------------
    // bit_cnt_reg already points at the next bit after each rising edge,
    // so the msb appears on the falling edge right after the header
    always_ff @(negedge port_clock or posedge port_select_n or posedge rst) begin
        if (rst || port_select_n) begin
            port_serial_out <= 1'b0;
            port_serial_out_oe <= 1'b0;
        end else begin
            port_serial_out <= rd_byte_reg[3'h7 - bit_cnt_reg];
            port_serial_out_oe <= rw_reg && (phase_reg == SCP_PH_DATA);
        end
    end

    // ------------------------------------------------------------------
    // crossing to clk_sys: quasi-static configuration bits
    // ------------------------------------------------------------------
    // each bit passes two flops; a multi-bit field may be seen torn for
    // one cycle right after a write, which its consumers tolerate
    logic [`SCP_CFG_WIDTH-1:0] cfg_port;
    logic [`SCP_CFG_WIDTH-1:0] cfg_meta_reg;
    logic [`SCP_CFG_WIDTH-1:0] cfg_sync_reg;

    // starts at the register reset values: no false power-up
    localparam logic [`SCP_CFG_WIDTH-1:0] cfg_rst_value = {`SCP_RST_AUDIO_PORT,
        4'(`SCP_RST_PWR_CLK), `SCP_RST_TX_CTRL};

    assign cfg_port = {aport_reg, pwr_clk_reg[3:0], tx_ctrl_reg};

    genvar gi;
    generate
        for (gi = 0; gi < `SCP_CFG_WIDTH; gi = gi + 1) begin : g_cfg_sync
            // two-flop synchroniser, first stage read by the second only
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    cfg_meta_reg[gi] <= cfg_rst_value[gi];
                    cfg_sync_reg[gi] <= cfg_rst_value[gi];
                end else begin
                    cfg_meta_reg[gi] <= cfg_port[gi];
                    cfg_sync_reg[gi] <= cfg_meta_reg[gi];
                end
            end
        end
    endgenerate

    scp_byte_t tx_s;
    logic [3:0] pc_s;
    scp_byte_t ap_s;

    assign tx_s = cfg_sync_reg[7:0];
    assign pc_s = cfg_sync_reg[11:8];
    assign ap_s = cfg_sync_reg[19:12];

    // ------------------------------------------------------------------
    // pin synchronisers for mode strap and external encoded stream
    // ------------------------------------------------------------------
    logic [1:0] hw_meta_reg;
    logic [1:0] ext_meta_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            hw_meta_reg <= 2'h0;
            ext_meta_reg <= 2'h0;
        end else begin
            hw_meta_reg <= {hw_meta_reg[0], hardware_mode};
            ext_meta_reg <= {ext_meta_reg[0], external_encoded_input};
        end
    end

    // ------------------------------------------------------------------
    // configuration outputs, registered from the synchronised copy
    // ------------------------------------------------------------------
    // held at documented reset values until the first synchronised copy,
    // so power-down reads as set from reset onward
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            // transmitter control
            block_start_direction <= 1'b0;
            validity_flag <= 1'b0;
            mute <= 1'b0;
            mono <= 1'b0;
            mono_channel_select <= 1'b0;
            shared_status_select <= 1'b0;

            // derived selects
            mono_audio_right <= 1'b0;
            status_a_right <= 1'b0;
            status_b_right <= 1'b1;

            // power and clock
            power_down <= 1'b1;
            soft_reset <= 1'b0;
            mclk_ratio <= 2'h1;

            // audio serial port
            audio_port_master <= 1'b0;
            bit_clock_rate <= 1'b0;
            word_length <= 2'h0;
            justification <= 1'b0;
            data_delay <= 1'b0;
            bit_clock_edge <= 1'b0;
            frame_sync_polarity <= 1'b0;
        end else begin
            // transmitter control
            block_start_direction <= tx_s[`SCP_TX_BLOCK_DIR];
            validity_flag <= tx_s[`SCP_TX_VALIDITY];
            mute <= tx_s[`SCP_TX_MUTE];
            mono <= tx_s[`SCP_TX_MONO];
            mono_channel_select <= tx_s[`SCP_TX_MONO_SEL];
            shared_status_select <= tx_s[`SCP_TX_SHARED];

            // audio source: select matters only in mono
            mono_audio_right <= tx_s[`SCP_TX_MONO] & tx_s[`SCP_TX_MONO_SEL];
            // status source per subframe: own channel unless shared
            status_a_right <= tx_s[`SCP_TX_SHARED] & tx_s[`SCP_TX_MONO_SEL];
            status_b_right <= !tx_s[`SCP_TX_SHARED] | tx_s[`SCP_TX_MONO_SEL];

            // power and clock
            power_down <= pc_s[`SCP_PC_POWER_DOWN];
            soft_reset <= pc_s[`SCP_PC_SOFT_RESET];
            mclk_ratio <= pc_s[`SCP_PC_MCLK_HI:`SCP_PC_MCLK_LO];

            // audio serial port
            audio_port_master <= ap_s[`SCP_AP_MASTER];
            bit_clock_rate <= ap_s[`SCP_AP_BCLK_RATE];
            word_length <= ap_s[`SCP_AP_WLEN_HI:`SCP_AP_WLEN_LO];
            justification <= ap_s[`SCP_AP_JUSTIFY];
            data_delay <= ap_s[`SCP_AP_DELAY];
            bit_clock_edge <= ap_s[`SCP_AP_BCLK_EDGE];
            frame_sync_polarity <= ap_s[`SCP_AP_SYNC_POL];
        end
    end

    // ------------------------------------------------------------------
    // balanced line driver source and forcing
    // ------------------------------------------------------------------
    logic line_src;
    logic line_force;

    // hardware mode ignores the bypass, soft-reset and output-disable bits; power_down still grounds the line
    assign line_src = (!hw_meta_reg[1] && tx_s[`SCP_TX_BYPASS]) ?
                      ext_meta_reg[1] : encoder_data;
    assign line_force = !hw_meta_reg[1] &&
                        (pc_s[`SCP_PC_POWER_DOWN] || pc_s[`SCP_PC_SOFT_RESET] ||
                         tx_s[`SCP_TX_OUT_DIS]);

    // both legs grounded when forced, complementary otherwise
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            line_out_pos <= 1'b0;
            line_out_neg <= 1'b0;
        end else if (line_force || power_down) begin
            line_out_pos <= 1'b0;
            line_out_neg <= 1'b0;
        end else begin
            line_out_pos <= line_src;
            line_out_neg <= !line_src;
        end
    end

endmodule : scp_ctrl

// File: hw/scp_map.svh
// scp_map.svh: register offsets, field positions and reset values of the
// serial control port and transmitter configuration block.
// assumes: included by bare name from the package and the design module.
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// ----------------------------------------------------------------------
// register offsets (6-bit port address space)
// ----------------------------------------------------------------------
`define SCP_ADDR_FACTORY 6'h00
`define SCP_ADDR_TX_CTRL 6'h01
`define SCP_ADDR_PWR_CLK 6'h02
`define SCP_ADDR_AUDIO_PORT 6'h03

// ----------------------------------------------------------------------
// reset values and power/clock write mask
// ----------------------------------------------------------------------
`define SCP_RST_TX_CTRL 8'h00
`define SCP_RST_PWR_CLK 8'h03
`define SCP_RST_AUDIO_PORT 8'h00
`define SCP_PWR_CLK_MASK 8'h0F

// ----------------------------------------------------------------------
// transmitter control fields
// ----------------------------------------------------------------------
`define SCP_TX_BLOCK_DIR 0
`define SCP_TX_VALIDITY 1
`define SCP_TX_MUTE 2
`define SCP_TX_BYPASS 3
`define SCP_TX_MONO 4
`define SCP_TX_MONO_SEL 5
`define SCP_TX_SHARED 6
`define SCP_TX_OUT_DIS 7

// ----------------------------------------------------------------------
// power-down and clock fields
// ----------------------------------------------------------------------
`define SCP_PC_POWER_DOWN 0
`define SCP_PC_MCLK_LO 1
`define SCP_PC_MCLK_HI 2
`define SCP_PC_SOFT_RESET 3

// ----------------------------------------------------------------------
// audio serial port fields
// ----------------------------------------------------------------------
`define SCP_AP_MASTER 0
`define SCP_AP_BCLK_RATE 1
`define SCP_AP_WLEN_LO 2
`define SCP_AP_WLEN_HI 3
`define SCP_AP_JUSTIFY 4
`define SCP_AP_DELAY 5
`define SCP_AP_BCLK_EDGE 6
`define SCP_AP_SYNC_POL 7

// ----------------------------------------------------------------------
// header byte fields, last bit index and config width
// ----------------------------------------------------------------------
`define SCP_HDR_RW 7
`define SCP_HDR_STEP 6
`define SCP_LAST_BIT 3'h7
`define SCP_CFG_WIDTH 20

`endif

// File: hw/scp_pkg.sv
// scp_pkg: types shared by the serial control port design.
// assumes: scp_map.svh sits on the include path.
package scp_pkg;
    `include "scp_map.svh"

    // ------------------------------------------------------------------
    // transfer phase of the port, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SCP_PH_HDR0 = 3'b001,
        SCP_PH_HDR1 = 3'b010,
        SCP_PH_DATA = 3'b100
    } scp_phase_t;

    typedef logic [7:0] scp_byte_t;
endpackage : scp_pkg

// File: tb/scp_ctrl_assertions.sv
// scp_ctrl_assertions: port and config checks for scp_ctrl.
// assumes: bound to scp_ctrl, sees its ports only.
`timescale 1ns/1ps
module scp_ctrl_assertions (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic port_clock,
    input wire logic port_select_n,
    input wire logic port_serial_out_oe,
    input wire logic hardware_mode,
    input wire logic line_out_pos,
    input wire logic line_out_neg,
    input wire logic power_down,
    input wire logic soft_reset,
    input wire logic [1:0] mclk_ratio,
    input wire logic mono,
    input wire logic mono_channel_select,
    input wire logic shared_status_select,
    input wire logic mono_audio_right,
    input wire logic status_a_right,
    input wire logic status_b_right
);
    // ------------------------------------------------------------------
    // helper history of the select bits
    // ------------------------------------------------------------------
    logic [2:0] sel_q1;
    logic [2:0] sel_q2;
    // derived selects register in the same cycle as their bits; compare only once the bits have held steady
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sel_q1 <= 3'h0;
            sel_q2 <= 3'h0;
        end else begin
            sel_q1 <= {mono, mono_channel_select, shared_status_select};
            sel_q2 <= sel_q1;
        end
    end
    property p_oe_idle;
        @(posedge clk_sys) disable iff (rst)
        port_select_n && $past(port_select_n) |-> !port_serial_out_oe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("serial out driven while idle");
    property p_oe_sel;
        @(negedge port_clock) disable iff (rst) port_serial_out_oe |-> !port_select_n;
    endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("serial out driven unselected");
    property p_rst_line;
        @(posedge clk_sys) disable iff (rst) $fell(rst) |-> !line_out_pos && !line_out_neg;
    endproperty
    a_rst_line: assert property (p_rst_line) else $error("line not grounded at reset");
    property p_rst_cfg;
        @(posedge clk_sys) disable iff (rst)
        $fell(rst) |-> power_down && !soft_reset && mclk_ratio == 2'h1;
    endproperty
    a_rst_cfg: assert property (p_rst_cfg) else $error("bad config reset values");
    property p_forced;
        @(posedge clk_sys) disable iff (rst)
        ((power_down || soft_reset) && !hardware_mode) [*4] |-> !line_out_pos && !line_out_neg;
    endproperty
    a_forced: assert property (p_forced) else $error("line not grounded");
    property p_quiet;
        @(posedge clk_sys) disable iff (rst) port_select_n [*6] |->
        $stable({power_down, soft_reset, mclk_ratio, mono, mono_channel_select});
    endproperty
    a_quiet: assert property (p_quiet) else $error("config moved while deselected");
    sequence s_sel_settled;
        {mono, mono_channel_select, shared_status_select} == sel_q1 && sel_q1 == sel_q2;
    endsequence
    property p_mono_src;
        @(posedge clk_sys) disable iff (rst)
        s_sel_settled |-> mono_audio_right == (mono && mono_channel_select);
    endproperty
    a_mono_src: assert property (p_mono_src) else $error("mono source wrong");
    property p_stat_a;
        @(posedge clk_sys) disable iff (rst)
        s_sel_settled |-> status_a_right == (shared_status_select && mono_channel_select);
    endproperty
    a_stat_a: assert property (p_stat_a) else $error("status a source wrong");
    property p_stat_b;
        @(posedge clk_sys) disable iff (rst)
        s_sel_settled |-> status_b_right == (!shared_status_select || mono_channel_select);
    endproperty
    a_stat_b: assert property (p_stat_b) else $error("status b source wrong");
    c_read: cover property (@(posedge clk_sys) port_serial_out_oe);
    c_mono: cover property (@(posedge clk_sys) mono_audio_right);
    c_power_up: cover property (@(posedge clk_sys) $fell(power_down));
endmodule : scp_ctrl_assertions

bind scp_ctrl scp_ctrl_assertions scp_ctrl_assertions_i (.clk_sys, .rst, .port_clock,
    .port_select_n, .port_serial_out_oe, .hardware_mode, .line_out_pos, .line_out_neg,
    .power_down, .soft_reset, .mclk_ratio, .mono, .mono_channel_select,
    .shared_status_select, .mono_audio_right, .status_a_right, .status_b_right);

// File: tb/scp_ctrl_tb_top.sv
// scp_ctrl_tb_top: self-checking bench for the control port block.
// assumes: scp_host drives the port; read bytes are checked in order.
`timescale 1ns/1ps
module scp_ctrl_tb_top;
    logic clk_sys, rst, hardware_mode, encoder_data, external_encoded_input;
    logic port_clock, port_select_n, port_serial_in, port_serial_out, port_serial_out_oe;
    logic line_out_pos, line_out_neg, block_start_direction, validity_flag, mute, mono;
    logic mono_channel_select, shared_status_select, mono_audio_right, status_a_right;
    logic status_b_right, power_down, soft_reset, audio_port_master, bit_clock_rate;
    logic justification, data_delay, bit_clock_edge, frame_sync_polarity, rd_valid, lsrc;
    logic [1:0] mclk_ratio, word_length;
    logic [7:0] rd_byte, ra, rb, rc;
    logic [7:0] exp_q[$];
    int seed, num_errors, checked, cycles, half;
    wire logic [7:0] tx_seen = {1'b0, shared_status_select, mono_channel_select, mono,
        1'b0, mute, validity_flag, block_start_direction};
    wire logic [7:0] pc_seen = {4'h0, soft_reset, mclk_ratio, power_down};
    wire logic [7:0] ap_seen = {frame_sync_polarity, bit_clock_edge, data_delay,
        justification, word_length, bit_clock_rate, audio_port_master};
    wire logic [7:0] src_seen = {5'h0, mono_audio_right, status_a_right, status_b_right};
    wire logic [7:0] line_seen = {6'h0, line_out_pos, line_out_neg};
    wire logic [7:0] rst_seen = {line_seen[1:0], port_serial_out_oe, pc_seen[3:0], mute};
    scp_ctrl scp_ctrl_i (.clk_sys, .rst, .port_clock, .port_select_n, .port_serial_in,
        .port_serial_out, .port_serial_out_oe, .hardware_mode, .encoder_data,
        .external_encoded_input, .line_out_pos, .line_out_neg, .block_start_direction,
        .validity_flag, .mute, .mono, .mono_channel_select, .shared_status_select,
        .mono_audio_right, .status_a_right, .status_b_right, .power_down, .soft_reset,
        .mclk_ratio, .audio_port_master, .bit_clock_rate, .word_length, .justification,
        .data_delay, .bit_clock_edge, .frame_sync_polarity);
    scp_host scp_host_i (.port_clock, .port_select_n, .port_serial_in, .port_serial_out,
        .rd_valid, .rd_byte);
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want) begin
            num_errors++;
            $display("mismatch at %0t: seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic close_out;
        $display("counts: checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic xfer(input logic rw, input logic st, input logic [5:0] a,
                        input logic [31:0] d, input int nbits);
        scp_host_i.access({rw, st, a, 8'($random(seed)), d}, 16 + nbits, half);
    endtask : xfer
    // expected bytes are queued before the frame leaves
    task automatic rd(input logic st, input logic [5:0] a, input logic [31:0] e, input int nb);
        for (int i = 0; i < nb; i++) exp_q.push_back(e[31 - 8 * i -: 8]);
        xfer(1'b1, st, a, 32'($random(seed)), 8 * nb);
    endtask : rd
    task automatic settle;
        repeat (5) @(posedge clk_sys);
        #1;
    endtask : settle
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // hang guard, generous over the roughly eight hundred cycles of traffic
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            close_out();
        end
    end
    always @(posedge rd_valid) check(rd_byte, exp_q.size() > 0 ? exp_q.pop_front() : ~rd_byte);
    initial begin
        seed = 32'hCBE1;
        half = 24;
        rst = 1'b1;
        hardware_mode = 1'b0;
        encoder_data = 1'b0;
        external_encoded_input = 1'b0;
        repeat (8) @(posedge clk_sys);
        #1 rst = 1'b0;
        settle();
        check(rst_seen, 8'h06);
        rd(1'b0, 6'h00, 32'h0000_0300, 4);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            half = (i % 2) ? 60 : 24;
            ra = 8'($random(seed));
            rb = 8'($random(seed));
            rc = 8'($random(seed));
            rb[2:1] = i[1:0];
            rc[3:2] = i[1:0];
            xfer(1'b0, 1'b0, 6'h01, {ra, rb, rc, 8'h00}, 24);
            settle();
            check(tx_seen, ra & 8'h77);
            check(pc_seen, rb & 8'h0F);
            check(ap_seen, rc);
            check(src_seen, {5'h0, ra[4] & ra[5], ra[6] & ra[5], !ra[6] | ra[5]});
            rd(1'b0, 6'h01, {ra, rb & 8'h0F, rc, 8'h00}, 3);
        end
        $display("test register fields done");
        half = 24;
        xfer(1'b0, 1'b1, 6'h3F, {rb, ~ra, ~rc, 8'h00}, 24);
        rd(1'b1, 6'h3F, {8'h00, ~ra, ~rc, 8'h00}, 3);
        rd(1'b0, 6'h02, {rb & 8'h0F, 24'h0}, 1);
        xfer(1'b0, 1'b0, 6'h01, {ra, 24'h0}, 4);
        rd(1'b0, 6'h01, {~ra, 24'h0}, 1);
        $display("test step and abort done");
        xfer(1'b0, 1'b0, 6'h02, {8'h02, 24'h0}, 8);
        for (int j = 0; j < 16; j++) begin
            @(posedge clk_sys);
            #1 hardware_mode = 1'b0;
            xfer(1'b0, 1'b0, 6'h01, {j[0], 3'h0, j[1], 3'h0, 24'h0}, 8);
            @(posedge clk_sys);
            #1 hardware_mode = j[2];
            encoder_data = j[3];
            external_encoded_input = !j[3];
            settle();
            lsrc = (!j[2] && j[1]) ? !j[3] : j[3];
            check(line_seen, (!j[2] && j[0]) ? 8'h00 : {6'h0, lsrc, !lsrc});
        end
        @(posedge clk_sys);
        #1 hardware_mode = 1'b0;
        xfer(1'b0, 1'b0, 6'h01, 32'h0, 8);
        settle();
        check(line_seen, 8'h02);
        xfer(1'b0, 1'b0, 6'h02, {8'h0A, 24'h0}, 8);
        settle();
        check(line_seen, 8'h00);
        check(8'(exp_q.size()), 8'h00);
        $display("test line driver done");
        close_out();
    end
endmodule : scp_ctrl_tb_top

// File: tb/scp_host.sv
// scp_host: host side of the serial control port.
// assumes: port clock idles low and only runs inside frames.
`timescale 1ns/1ps
module scp_host (
    output logic port_clock,
    output logic port_select_n,
    output logic port_serial_in,
    input wire logic port_serial_out,
    output logic rd_valid,
    output logic [7:0] rd_byte
);
    initial begin
        port_clock = 1'b0;
        port_select_n = 1'b1;
        port_serial_in = 1'b0;
        rd_valid = 1'b0;
        rd_byte = 8'h00;
    end
    // ------------------------------------------------------------------
    // one frame: header, ignored byte, data; read bytes pulse rd_valid
    // ------------------------------------------------------------------
    task automatic access(input logic [47:0] frame, input int nbits, input int half);
        logic [7:0] sh;
        sh = 8'h00;
        port_select_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            port_serial_in = frame[47 - i];
            #(half);
            port_clock = 1'b1;
            sh = {sh[6:0], port_serial_out};
            #(half);
            port_clock = 1'b0;
            if (frame[47] && i >= 16 && i % 8 == 7) begin
                rd_byte = sh;
                rd_valid = 1'b1;
                #1 rd_valid = 1'b0;
            end
        end
        port_select_n = 1'b1;
        // released line must not keep showing the last bit
        port_serial_in = ~port_serial_in;
        #(4 * half);
    endtask : access
endmodule : scp_host
